// >>> dv/ppsc_ctrl_model.sv
`timescale 1ns/1ns
module ppsc_ctrl_model (
  input wire logic clk_in,
  output logic init_n_out,
  output logic halt_n_out
);
  import ppsc_pkg::*;
  initial begin
    init_n_out = 1'b1;
    halt_n_out = 1'b1;
  end
  // ------------------------------------------------------------
  // hardware standby entry and exit
  // ------------------------------------------------------------
  // pins change just after the falling edge, never on the sampling edge
  task automatic enter_hw(input logic keep);
    @(negedge clk_in);
    if (keep) begin
      init_n_out = 1'b0;
      repeat (PPSC_KEEP_LEAD_CYC) @(negedge clk_in);
    end
    halt_n_out = 1'b0;
  endtask
  // init is pulled low before halt rises and rises one cycle after it
  task automatic exit_hw();
    @(negedge clk_in);
    init_n_out = 1'b0;
    repeat (PPSC_EXIT_LEAD_CYC) @(negedge clk_in);
    halt_n_out = 1'b1;
    @(negedge clk_in);
    init_n_out = 1'b1;
  endtask
endmodule

// >>> dv/ppsc_port_state_tb_top.sv
`timescale 1ns/1ns
module ppsc_port_state_tb_top;
  import ppsc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] mode = PPSC_MODE1;
  logic init_n, halt_n, sw, slp, keep, av, cdir;
  logic [15:0] addr, adir, alat, a_pin, a_oe;
  logic [7:0] gdir, glat, gpu, puse, pdat, g_pin, g_oe, g_pu;
  logic c_pin, c_oe, p_init;
  logic [4:0] st;
  int num_errors = 0;
  int check_count = 0;
  always #4 clk = ~clk;
  ppsc_ctrl_model i_ppsc_ctrl_model (.clk_in(clk), .init_n_out(init_n),
    .halt_n_out(halt_n));
  ppsc_port_state i_ppsc_port_state (.CLK_IN(clk), .RST_IN(rst),
    .MODE_IN(mode), .HARD_INIT_PIN_N_IN(init_n),
    .LOW_POWER_HALT_PIN_N_IN(halt_n), .SW_STANDBY_IN(sw),
    .SLEEP_IN(slp), .INTERNAL_MEMORY_KEEP_ENABLE_IN(keep),
    .ADDR_IN(addr), .ADDR_VALID_IN(av), .ADDR_DIR_IN(adir),
    .ADDR_LATCH_IN(alat), .CLK_DIR_IN(cdir), .GP_DIR_IN(gdir),
    .PORT_OUTPUT_LATCH_IN(glat), .INPUT_PULLUP_SELECT_IN(gpu),
    .PERIPH_USE_IN(puse), .PERIPH_DATA_IN(pdat), .ADDR_PIN_OUT(a_pin),
    .ADDR_PIN_OE_N_OUT(a_oe), .CLK_PIN_OUT(c_pin),
    .CLK_PIN_OE_N_OUT(c_oe), .GP_PIN_OUT(g_pin), .GP_PIN_OE_N_OUT(g_oe),
    .GP_PULLUP_OUT(g_pu), .PERIPH_INIT_OUT(p_init), .STATE_OUT(st));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic go(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [15:0] got, exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t pin got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_st(input logic [4:0] got, input ppsc_state_t exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t state got %h exp %h", $time, got, exp);
    end
  endtask
  // mode is static, so it only changes under reset
  task automatic set_mode(input logic [1:0] m);
    rst = 1'b1;
    mode = m;
    go(2);
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_mode1();
    logic c_prev;
    chk_st(st, PPSC_ST_RESET);
    chk(a_oe, 16'h0000);
    chk(a_pin, 16'h0000);
    rst = 1'b0;
    addr = 16'hA55A;
    av = 1'b1;
    go(2);
    chk(a_pin, 16'hA55A);
    chk(a_oe, 16'h0000);
    av = 1'b0;
    addr = 16'h1234;
    slp = 1'b1;
    go(2);
    chk(a_pin, 16'hA55A);
    chk(16'(c_oe), 16'h0000);
    c_prev = c_pin;
    go(1);
    chk(16'(c_pin), c_prev ? 16'h0000 : 16'h0001);
    slp = 1'b0;
    sw = 1'b1;
    go(2);
    chk(a_pin, 16'h0000);
    chk(16'({c_oe, c_pin, p_init}), 16'h0003);
    sw = 1'b0;
    keep = 1'b1;
    i_ppsc_ctrl_model.enter_hw(1'b1);
    go(2);
    chk_st(st, PPSC_ST_HSTBY);
    chk(a_oe, 16'hFFFF);
    chk(16'({c_oe, g_oe}), 16'h01FF);
    i_ppsc_ctrl_model.exit_hw();
    go(2);
    chk_st(st, PPSC_ST_NORM);
  endtask
  task automatic t_mode2();
    set_mode(PPSC_MODE2);
    chk(a_oe, 16'hFFFF);
    rst = 1'b0;
    adir = 16'hFF00;
    addr = 16'hBEEF;
    av = 1'b1;
    go(2);
    chk(a_oe, 16'h00FF);
    chk(a_pin & 16'hFF00, 16'hBE00);
    sw = 1'b1;
    go(2);
    chk(a_oe, 16'h00FF);
    chk(a_pin & 16'hFF00, 16'h0000);
    sw = 1'b0;
    keep = 1'b0;
    i_ppsc_ctrl_model.enter_hw(1'b0);
    go(2);
    chk_st(st, PPSC_ST_HSTBY);
    i_ppsc_ctrl_model.exit_hw();
    go(2);
  endtask
  task automatic t_mode3_clk();
    set_mode(PPSC_MODE3);
    rst = 1'b0;
    cdir = 1'b0;
    go(2);
    chk(16'(c_oe), 16'h0001);
    cdir = 1'b1;
    go(2);
    chk(16'(c_oe), 16'h0000);
    slp = 1'b1;
    go(2);
    chk(16'(c_oe), 16'h0000);
    cdir = 1'b0;
    go(2);
    chk(16'(c_oe), 16'h0001);
    slp = 1'b0;
    sw = 1'b1;
    go(2);
    chk(16'(c_oe), 16'h0001);
    cdir = 1'b1;
    go(2);
    chk(16'({c_oe, c_pin}), 16'h0001);
    sw = 1'b0;
    go(2);
  endtask
  // peripheral data on bit 7 must not survive into software standby
  task automatic t_gp();
    gdir = 8'hF0;
    glat = 8'hA5;
    gpu = 8'h0C;
    puse = 8'h80;
    pdat = 8'h00;
    go(2);
    chk(16'(g_oe), 16'h000F);
    chk(16'(g_pin & 8'hF0), 16'h0020);
    slp = 1'b1;
    go(1);
    glat = 8'h5A;
    go(2);
    chk(16'(g_pin & 8'hF0), 16'h0020);
    chk({g_oe, g_pu}, 16'h0F0C);
    slp = 1'b0;
    pdat = 8'hFF;
    go(2);
    sw = 1'b1;
    go(2);
    chk(16'(g_pin & 8'hF0), 16'h0050);
    chk(16'(g_oe), 16'h000F);
  endtask
  task automatic t_prio();
    slp = 1'b1;
    go(2);
    chk_st(st, PPSC_ST_SSTBY);
    fork
      i_ppsc_ctrl_model.enter_hw(1'b1);
      begin
        go(5);
        chk_st(st, PPSC_ST_RESET);
      end
    join
    go(2);
    chk_st(st, PPSC_ST_HSTBY);
    i_ppsc_ctrl_model.exit_hw();
    sw = 1'b0;
    go(2);
    chk_st(st, PPSC_ST_SLEEP);
    slp = 1'b0;
    go(2);
    chk_st(st, PPSC_ST_NORM);
  endtask
  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    {sw, slp, keep, av, cdir} = 5'h00;
    {addr, adir, alat} = {16'h0000, 16'hFFFF, 16'h0000};
    {gdir, glat, gpu, puse, pdat} = 40'h00;
    go(10);
    t_mode1();
    t_mode2();
    t_mode3_clk();
    t_gp();
    t_prio();
    report_and_stop();
  end
  // the whole run is under 150 cycles, so this is a wide margin
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end
endmodule

// >>> logic/ppsc_gpio_bit.sv
`timescale 1ns/1ns
module ppsc_gpio_bit
  import ppsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [4:0] state_in,
  input wire logic dir_in,
  input wire logic latch_in,
  input wire logic pullup_sel_in,
  output logic pin_out,
  output logic pin_oe_n_out,
  output logic pullup_out
);
  import ppsc_pkg::*;
  logic held;
  logic next_held;
  logic active;
  // ----------------------------------------------------------------
  // held level for the keep-previous states
  // ----------------------------------------------------------------
  assign active = (state_in == PPSC_ST_NORM);
  always_comb begin
    // sw standby tracks the port latch so a later sleep keeps that level
    next_held = (active || state_in == PPSC_ST_SSTBY) ? latch_in : held;
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      held <= 1'b0;
    end else begin
      held <= next_held;
    end
  end
  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  always_comb begin
    pin_out = 1'b0;
    pin_oe_n_out = 1'b1;
    pullup_out = 1'b0;
    case (state_in)
      PPSC_ST_HSTBY, PPSC_ST_RESET: begin
        pin_oe_n_out = 1'b1;
      end
      PPSC_ST_NORM: begin
        pin_out = latch_in;
        pin_oe_n_out = ~dir_in;
        pullup_out = ~dir_in & pullup_sel_in;
      end
      PPSC_ST_SSTBY: begin
        pin_out = latch_in;
        pin_oe_n_out = ~dir_in;
        pullup_out = ~dir_in & pullup_sel_in;
      end
      PPSC_ST_SLEEP: begin
        pin_out = held;
        pin_oe_n_out = ~dir_in;
        pullup_out = ~dir_in & pullup_sel_in;
      end
      default: begin
        pin_oe_n_out = 1'b1;
      end
    endcase
  end
endmodule

// >>> logic/ppsc_pkg.sv
package ppsc_pkg;
  // -----------------------------------------------------------------
  // widths and encodings
  // -----------------------------------------------------------------
  localparam int PPSC_AW = 16;
  localparam int PPSC_GW = 8;
  localparam logic [1:0] PPSC_MODE1 = 2'h1;
  localparam logic [1:0] PPSC_MODE2 = 2'h2;
  localparam logic [1:0] PPSC_MODE3 = 2'h3;
  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [PPSC_AW-1:0] PPSC_ADDR_RST = 16'h0000;
  localparam logic [PPSC_GW-1:0] PPSC_GP_RST = 8'h00;
  // -----------------------------------------------------------------
  // hardware standby entry and exit timing, kept by the board controller
  // -----------------------------------------------------------------
  localparam int PPSC_CLK_MHZ = 125;
  localparam int PPSC_KEEP_LEAD_CYC = 10;
  localparam int PPSC_EXIT_LEAD_NS = 100;
  localparam int PPSC_EXIT_LEAD_CYC =
    (PPSC_EXIT_LEAD_NS * PPSC_CLK_MHZ + 999) / 1000;
  localparam int PPSC_CNT_W = 5;
  typedef enum logic [4:0] {
    PPSC_ST_NORM = 5'h01,
    PPSC_ST_SLEEP = 5'h02,
    PPSC_ST_SSTBY = 5'h04,
    PPSC_ST_RESET = 5'h08,
    PPSC_ST_HSTBY = 5'h10
  } ppsc_state_t;
endpackage

// >>> logic/ppsc_port_state.sv
`timescale 1ns/1ns
// How it works
// - mode 1 address pins: low in reset/sw standby, float hw, hold sleep
// - mode 2 address: float in reset; sw standby low if output else float
// - mode 2 normal: address output or input per direction bit
// - sw standby clock pin high; mode 3 only if direction bit set
// - sleep: clock out; mode 3 floats it when direction bit clear
// - mode 3 normal: clock out if direction set, else input
// - held input pins float, pull-up only if its select bit set
// - held output pins keep level from just before sleep; sw standby follows the latch
// - sw standby entry resets peripherals; pins revert to port control
// - general pins drive or read per their direction bit; peripheral-owned pins drive, reset/hw float
module ppsc_port_state
  import ppsc_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic [1:0] MODE_IN,
  input wire logic HARD_INIT_PIN_N_IN,
  input wire logic LOW_POWER_HALT_PIN_N_IN,
  input wire logic SW_STANDBY_IN,
  input wire logic SLEEP_IN,
  input wire logic INTERNAL_MEMORY_KEEP_ENABLE_IN,
  input wire logic [ppsc_pkg::PPSC_AW-1:0] ADDR_IN,
  input wire logic ADDR_VALID_IN,
  input wire logic [ppsc_pkg::PPSC_AW-1:0] ADDR_DIR_IN,
  input wire logic [ppsc_pkg::PPSC_AW-1:0] ADDR_LATCH_IN,
  input wire logic CLK_DIR_IN,
  input wire logic [ppsc_pkg::PPSC_GW-1:0] GP_DIR_IN,
  input wire logic [ppsc_pkg::PPSC_GW-1:0] PORT_OUTPUT_LATCH_IN,
  input wire logic [ppsc_pkg::PPSC_GW-1:0] INPUT_PULLUP_SELECT_IN,
  input wire logic [ppsc_pkg::PPSC_GW-1:0] PERIPH_USE_IN,
  input wire logic [ppsc_pkg::PPSC_GW-1:0] PERIPH_DATA_IN,
  output logic [ppsc_pkg::PPSC_AW-1:0] ADDR_PIN_OUT,
  output logic [ppsc_pkg::PPSC_AW-1:0] ADDR_PIN_OE_N_OUT,
  output logic CLK_PIN_OUT,
  output logic CLK_PIN_OE_N_OUT,
  output logic [ppsc_pkg::PPSC_GW-1:0] GP_PIN_OUT,
  output logic [ppsc_pkg::PPSC_GW-1:0] GP_PIN_OE_N_OUT,
  output logic [ppsc_pkg::PPSC_GW-1:0] GP_PULLUP_OUT,
  output logic PERIPH_INIT_OUT,
  output logic [4:0] STATE_OUT
);
  import ppsc_pkg::*;

  ppsc_state_t state;
  ppsc_state_t next_state;
  logic [PPSC_AW-1:0] addr_last;
  logic [PPSC_AW-1:0] next_addr_last;
  logic [PPSC_GW-1:0] periph_en;
  logic [PPSC_GW-1:0] next_periph_en;
  logic [PPSC_GW-1:0] gp_dir_eff;
  logic [PPSC_GW-1:0] gp_latch_eff;
  logic [PPSC_GW-1:0] gp_own;
  logic [PPSC_AW-1:0] held_a;
  logic clk_div;
  logic next_clk_div;

  // ---------------------------------------------------------------
  // state decode
  // ---------------------------------------------------------------
  function automatic ppsc_state_t decode(input logic hs_n, input logic rs,
                                         input logic ss, input logic sl);
    if (!hs_n) begin
      decode = PPSC_ST_HSTBY;
    end else if (rs) begin
      decode = PPSC_ST_RESET;
    end else if (ss) begin
      decode = PPSC_ST_SSTBY;
    end else if (sl) begin
      decode = PPSC_ST_SLEEP;
    end else begin
      decode = PPSC_ST_NORM;
    end
  endfunction

  // init pin low acts as reset; the controller's entry and exit ordering
  // keeps memory intact, nothing here times it
  always_comb begin
    next_state = decode(LOW_POWER_HALT_PIN_N_IN, ~HARD_INIT_PIN_N_IN,
                        SW_STANDBY_IN, SLEEP_IN);
  end

  // ---------------------------------------------------------------
  // last address, peripheral ownership, clock mirror
  // ---------------------------------------------------------------
  always_comb begin
    next_addr_last = addr_last;
    if (state == PPSC_ST_NORM && ADDR_VALID_IN) begin
      next_addr_last = ADDR_IN;
    end
    next_periph_en = PERIPH_USE_IN;
    if (state == PPSC_ST_SSTBY || state == PPSC_ST_RESET ||
        state == PPSC_ST_HSTBY) begin
      next_periph_en = PPSC_GP_RST;
    end
    next_clk_div = ~clk_div;
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      state <= PPSC_ST_RESET;
      addr_last <= PPSC_ADDR_RST;
      periph_en <= PPSC_GP_RST;
      clk_div <= 1'b0;
    end else begin
      state <= next_state;
      addr_last <= next_addr_last;
      periph_en <= next_periph_en;
      clk_div <= next_clk_div;
    end
  end

  assign STATE_OUT = state;
  assign PERIPH_INIT_OUT = (state == PPSC_ST_SSTBY);
  // borrowed pins look like outputs of the peripheral while it owns them;
  // software standby drops ownership at once, not one cycle late
  assign gp_own = (state == PPSC_ST_SSTBY) ? PPSC_GP_RST : periph_en;
  assign gp_dir_eff = GP_DIR_IN | gp_own;
  assign gp_latch_eff = (gp_own & PERIPH_DATA_IN) |
                        (~gp_own & PORT_OUTPUT_LATCH_IN);

  // ---------------------------------------------------------------
  // general-purpose pins
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < PPSC_GW; gi++) begin : g_gp
      ppsc_gpio_bit u_bit (
        .clk_in(CLK_IN),
        .rst_in(RST_IN),
        .state_in(state),
        .dir_in(gp_dir_eff[gi]),
        .latch_in(gp_latch_eff[gi]),
        .pullup_sel_in(INPUT_PULLUP_SELECT_IN[gi]),
        .pin_out(GP_PIN_OUT[gi]),
        .pin_oe_n_out(GP_PIN_OE_N_OUT[gi]),
        .pullup_out(GP_PULLUP_OUT[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // address pins
  // ---------------------------------------------------------------
  // mode 1 outputs the address in normal run; mode 3 mirrors the latch
  always_comb begin
    ADDR_PIN_OUT = PPSC_ADDR_RST;
    ADDR_PIN_OE_N_OUT = '1;
    held_a = (MODE_IN == PPSC_MODE3) ? ADDR_LATCH_IN : addr_last;
    case (state)
      PPSC_ST_HSTBY: begin
        ADDR_PIN_OE_N_OUT = '1;
      end
      PPSC_ST_RESET: begin
        if (MODE_IN == PPSC_MODE1) begin
          ADDR_PIN_OE_N_OUT = '0;
        end else begin
          ADDR_PIN_OE_N_OUT = '1;
        end
      end
      PPSC_ST_SSTBY: begin
        if (MODE_IN == PPSC_MODE1) begin
          ADDR_PIN_OE_N_OUT = '0;
        end else if (MODE_IN == PPSC_MODE2) begin
          ADDR_PIN_OUT = held_a & ~ADDR_DIR_IN;
          ADDR_PIN_OE_N_OUT = ~ADDR_DIR_IN;
        end else begin
          ADDR_PIN_OUT = held_a;
          ADDR_PIN_OE_N_OUT = ~ADDR_DIR_IN;
        end
      end
      PPSC_ST_SLEEP: begin
        ADDR_PIN_OUT = held_a;
        ADDR_PIN_OE_N_OUT = (MODE_IN == PPSC_MODE1) ? '0 : ~ADDR_DIR_IN;
      end
      PPSC_ST_NORM: begin
        if (MODE_IN == PPSC_MODE1) begin
          ADDR_PIN_OUT = ADDR_IN;
          ADDR_PIN_OE_N_OUT = '0;
        end else if (MODE_IN == PPSC_MODE2) begin
          ADDR_PIN_OUT = ADDR_IN;
          ADDR_PIN_OE_N_OUT = ~ADDR_DIR_IN;
        end else begin
          ADDR_PIN_OUT = ADDR_LATCH_IN;
          ADDR_PIN_OE_N_OUT = ~ADDR_DIR_IN;
        end
      end
      default: begin
        ADDR_PIN_OE_N_OUT = '1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // clock output pin
  // ---------------------------------------------------------------
  // clock shown as a divided mirror since one clock domain is allowed
  always_comb begin
    CLK_PIN_OUT = 1'b0;
    CLK_PIN_OE_N_OUT = 1'b1;
    case (state)
      PPSC_ST_HSTBY: begin
        CLK_PIN_OE_N_OUT = 1'b1;
      end
      PPSC_ST_RESET: begin
        CLK_PIN_OUT = clk_div;
        CLK_PIN_OE_N_OUT = (MODE_IN == PPSC_MODE3);
      end
      PPSC_ST_SSTBY: begin
        CLK_PIN_OUT = 1'b1;
        CLK_PIN_OE_N_OUT = (MODE_IN == PPSC_MODE3) & ~CLK_DIR_IN;
      end
      PPSC_ST_SLEEP, PPSC_ST_NORM: begin
        CLK_PIN_OUT = clk_div;
        CLK_PIN_OE_N_OUT = (MODE_IN == PPSC_MODE3) & ~CLK_DIR_IN;
      end
      default: begin
        CLK_PIN_OE_N_OUT = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_hstby_float;
    @(posedge CLK_IN) disable iff (RST_IN)
    state == PPSC_ST_HSTBY |-> (&ADDR_PIN_OE_N_OUT) && CLK_PIN_OE_N_OUT;
  endproperty
  a_hstby_float: assert property (p_hstby_float)
    else $error("pins not floating in hardware standby");
  property p_m1_sstby_low;
    @(posedge CLK_IN) disable iff (RST_IN)
    state == PPSC_ST_SSTBY && MODE_IN == PPSC_MODE1 |->
      ADDR_PIN_OUT == '0 && ADDR_PIN_OE_N_OUT == '0;
  endproperty
  a_m1_sstby_low: assert property (p_m1_sstby_low)
    else $error("mode 1 address not low in sw standby");
  property p_m2_reset_float;
    @(posedge CLK_IN) disable iff (RST_IN)
    state == PPSC_ST_RESET && MODE_IN == PPSC_MODE2 |->
      &ADDR_PIN_OE_N_OUT;
  endproperty
  a_m2_reset_float: assert property (p_m2_reset_float)
    else $error("mode 2 address driven in reset");
  property p_sstby_clk;
    @(posedge CLK_IN) disable iff (RST_IN)
    state == PPSC_ST_SSTBY |->
      CLK_PIN_OE_N_OUT == ((MODE_IN == PPSC_MODE3) && !CLK_DIR_IN);
  endproperty
  a_sstby_clk: assert property (p_sstby_clk)
    else $error("clock pin wrong in sw standby");
  property p_decode;
    @(posedge CLK_IN) disable iff (RST_IN)
    !LOW_POWER_HALT_PIN_N_IN |=> state == PPSC_ST_HSTBY;
  endproperty
  a_decode: assert property (p_decode)
    else $error("halt pin did not force hardware standby");
  property p_periph_init;
    @(posedge CLK_IN) disable iff (RST_IN)
    state == PPSC_ST_SSTBY ##1 state == PPSC_ST_SSTBY |-> periph_en == '0;
  endproperty
  a_periph_init: assert property (p_periph_init)
    else $error("peripheral kept pins in sw standby");
  property p_sleep_hold;
    @(posedge CLK_IN) disable iff (RST_IN)
    state == PPSC_ST_SLEEP && MODE_IN == PPSC_MODE1 |->
      ADDR_PIN_OUT == addr_last;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("sleep lost last address");
  property p_m2_norm;
    @(posedge CLK_IN) disable iff (RST_IN)
    state == PPSC_ST_NORM && MODE_IN == PPSC_MODE2 |->
      ADDR_PIN_OE_N_OUT == ~ADDR_DIR_IN;
  endproperty
  a_m2_norm: assert property (p_m2_norm)
    else $error("mode 2 address direction wrong");
  property p_m2_sstby;
    @(posedge CLK_IN) disable iff (RST_IN)
    state == PPSC_ST_SSTBY && MODE_IN == PPSC_MODE2 |->
      ADDR_PIN_OE_N_OUT == ~ADDR_DIR_IN && (ADDR_PIN_OUT & ADDR_DIR_IN) == '0;
  endproperty
  a_m2_sstby: assert property (p_m2_sstby)
    else $error("mode 2 address wrong in sw standby");
  c_sleep: cover property (@(posedge CLK_IN) state == PPSC_ST_SLEEP);
  c_sstby: cover property (@(posedge CLK_IN) state == PPSC_ST_SSTBY);
  c_hstby: cover property (@(posedge CLK_IN) state == PPSC_ST_HSTBY);
  c_keep: cover property (@(posedge CLK_IN)
    state == PPSC_ST_HSTBY && INTERNAL_MEMORY_KEEP_ENABLE_IN);
endmodule
